/* File: common/lbd_pkg.sv */
// shared constants, types and helpers for the local bus decoder
package lbd_pkg;
	// decoder registers (byte addresses)
	localparam logic [31:0] BOOT_CTRL_ADDR  = 32'hfff42040;
	localparam logic [31:0] DRAM_CTRL_ADDR  = 32'hfff42048;
	localparam logic [31:0] DRAM_BASE_ADDR  = 32'hfff4204c;
	localparam logic [31:0] SRAM_BASE_ADDR  = 32'hfff42050;
	localparam logic [31:0] TIMER_CTRL_ADDR = 32'hfff42054;
	localparam int          BOOT_LOW_OFF_BIT = 20;
	localparam int          DRAM_EN_BIT      = 24;
	localparam int          SRAM_EN_BIT      = 0;
	localparam int          TIMER_EN_BIT     = 0;
	localparam logic [31:0] REG_RST          = 32'h0;
	// access sizes and transfer types
	localparam logic [1:0]  SZ_LONG = 2'h0;
	localparam logic [1:0]  SZ_BYTE = 2'h1;
	localparam logic [1:0]  SZ_WORD = 2'h2;
	localparam logic [1:0]  TT_MAX  = 2'h2;
	// fixed map
	localparam logic [31:0] BOOT_HI_LO  = 32'hff800000;
	localparam logic [31:0] BOOT_HI_HI  = 32'hffbfffff;
	localparam logic [31:0] BOOT_LOW_HI = 32'h003fffff;
	localparam int          BOOT_SEC_BIT = 21;
	localparam int          BOOT_DEV_AW  = 20;
	localparam logic [31:0] SRAM_DEF_LO = 32'hffe00000;
	localparam logic [31:0] SRAM_DEF_HI = 32'hffe7ffff;
	localparam logic [31:0] LOCAL_CTRL_STATUS_REGS_LO     = 32'hfff40000;
	localparam logic [31:0] LOCAL_CTRL_STATUS_REGS_HI     = 32'hfff400ff;
	localparam logic [31:0] GLOBAL_CTRL_STATUS_REGS_LO     = 32'hfff40100;
	localparam logic [31:0] GLOBAL_CTRL_STATUS_REGS_HI     = 32'hfff401ff;
	localparam logic [31:0] MEMCTL_LO   = 32'hfff42000;
	localparam logic [31:0] MEMCTL_HI   = 32'hfff42fff;
	localparam logic [31:0] SCC_LO      = 32'hfff45000;
	localparam logic [31:0] SCC_HI      = 32'hfff45fff;
	localparam logic [31:0] LAN_LO      = 32'hfff46000;
	localparam logic [31:0] LAN_HI      = 32'hfff46fff;
	localparam logic [31:0] SCSI_LO     = 32'hfff47000;
	localparam logic [31:0] SCSI_HI     = 32'hfff47fff;
	localparam logic [31:0] IPIO_LO     = 32'hfff58000;
	localparam logic [31:0] IPIO_HI     = 32'hfff583ff;
	localparam logic [31:0] PAIR_LO     = 32'hfff58400;
	localparam logic [31:0] PAIR_HI     = 32'hfff587ff;
	localparam int          PAIR_CD_BIT = 8;
	localparam logic [31:0] MODREG_LO   = 32'hfffbc000;
	localparam logic [31:0] MODREG_HI   = 32'hfffbc01f;
	localparam logic [31:0] NV_LO       = 32'hfffc0000;
	localparam logic [31:0] NV_DIS_LO   = 32'hfffc8000;
	localparam logic [31:0] NV_EN_LO    = 32'hfffcc000;
	localparam logic [31:0] NV_HI       = 32'hfffcffff;
	localparam logic [31:0] VME16_LO    = 32'hffff0000;
	localparam logic [31:0] DRAM_WIN_BYTES = 32'h00800000;
	localparam logic [31:0] SRAM_WIN_BYTES = 32'h00200000;
	localparam int          LB_TIMEOUT_DEF = 256;
	// controller software registers (word index) and fields
	localparam logic [2:0]  H_ADDR_IDX = 3'h0;
	localparam logic [2:0]  H_DATA_IDX = 3'h1;
	localparam logic [2:0]  H_CTRL_IDX = 3'h2;
	localparam logic [2:0]  H_STAT_IDX = 3'h3;
	localparam logic [2:0]  H_RDAT_IDX = 3'h4;
	localparam int          HC_WRITE = 0;
	localparam int          HC_SIZE  = 1;
	localparam int          HC_TT    = 3;
	localparam int          HC_SPLIT = 5;

	typedef enum logic [3:0] {
		TGT_NONE, TGT_BOOT, TGT_MEMCTL, TGT_DRAM, TGT_SRAM, TGT_EXT,
		TGT_LOCAL_CTRL_STATUS_REGS, TGT_GLOBAL_CTRL_STATUS_REGS, TGT_SCC, TGT_LAN, TGT_SCSI, TGT_IP_IO,
		TGT_PAIR_AB, TGT_PAIR_CD, TGT_MODREG, TGT_NVRAM
	} target_t;

	// address inside an inclusive range
	function automatic logic in_range(input logic [31:0] a, lo, hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_range

	// byte lanes of an access, bit 3 is data[31:24] (offset 0)
	function automatic logic [3:0] byte_lanes(input logic [1:0] sz, input logic [1:0] a);
		unique case (sz)
			SZ_BYTE: return 4'h8 >> a;
			SZ_WORD: return a[1] ? 4'h3 : 4'hc;
			default: return 4'hf;
		endcase
	endfunction : byte_lanes
endpackage : lbd_pkg

/* File: common/local_bus_if.sv */
// local bus between a master and the address decoder
`timescale 1ns/10ps
interface local_bus_if;
	import lbd_pkg::*;
	logic        req;   // one-cycle start of a transfer
	logic [31:0] addr;
	logic [1:0]  size;
	logic        write;
	logic [1:0]  tt;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        ack;   // one-cycle normal end
	logic        transfer_error_ack;   // one-cycle error end

	modport master  (output req, addr, size, write, tt, wdata, input rdata, ack, transfer_error_ack);
	modport decoder (input req, addr, size, write, tt, wdata, output rdata, ack, transfer_error_ack);
endinterface : local_bus_if

/* File: rtl/boot_byte_packer.sv */
// assembles 32-bit boot memory transfers from an 8-bit private bus
`timescale 1ns/10ps
module boot_byte_packer
	import lbd_pkg::*;
(
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	// request from the decoder
	input  wire logic                   start,
	input  wire logic [BOOT_DEV_AW-1:0] base_addr,
	input  wire logic [3:0]             lanes,
	input  wire logic                   write,
	input  wire logic [31:0]            wdata,
	input  wire logic                   wr_allow,
	output logic                        done,
	output logic [31:0]                 rdata,
	// 8-bit private bus
	output logic [BOOT_DEV_AW-1:0]      dev_addr,
	output logic                        dev_rd,
	output logic                        dev_wr,
	output logic [7:0]                  dev_wdata,
	input  wire logic [7:0]             dev_rdata
);
	typedef enum logic {P_IDLE, P_BYTE} pk_state_t;
	pk_state_t  state;
	logic [3:0] pend;
	logic [1:0] cur;
	logic [3:0] rest;
	logic       is_wr;

	// first pending lane, lowest byte offset first
	function automatic logic [1:0] first_lane(input logic [3:0] m);
		if (m[3]) return 2'h0;
		if (m[2]) return 2'h1;
		if (m[1]) return 2'h2;
		return 2'h3;
	endfunction : first_lane

	assign rest = pend & ~(4'h8 >> cur);

	// one private-bus byte per cycle; upper address bits drop so contents repeat
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state     <= P_IDLE;
			pend      <= 4'h0;
			cur       <= 2'h0;
			is_wr     <= 1'b0;
			done      <= 1'b0;
			rdata     <= 32'h0;
			dev_addr  <= '0;
			dev_rd    <= 1'b0;
			dev_wr    <= 1'b0;
			dev_wdata <= 8'h0;
		end else begin
			done <= 1'b0;
			unique case (state)
				P_IDLE: begin
					if (start) begin
						pend      <= lanes;
						cur       <= first_lane(lanes);
						is_wr     <= write;
						dev_addr  <= {base_addr[BOOT_DEV_AW-1:2], first_lane(lanes)}; // R5
						dev_rd    <= !write;
						dev_wr    <= write && wr_allow;
						dev_wdata <= wdata[8*(3-first_lane(lanes)) +: 8];
						state     <= P_BYTE;
					end
				end
				P_BYTE: begin
					if (!is_wr)
						rdata[8*(3-cur) +: 8] <= dev_rdata; // R5
					pend <= rest;
					if (rest == 4'h0) begin
						dev_rd <= 1'b0;
						dev_wr <= 1'b0;
						done   <= 1'b1;
						state  <= P_IDLE;
					end else begin
						cur       <= first_lane(rest);
						dev_addr  <= {dev_addr[BOOT_DEV_AW-1:2], first_lane(rest)};
						dev_wdata <= wdata[8*(3-first_lane(rest)) +: 8];
					end
				end
			endcase
		end
	end
endmodule : boot_byte_packer

/* File: rtl/local_bus_decoder.sv */
// local bus address decoder with boot, memory and local i/o steering
// Contract
// R1: boot decode on at reset, high and low
// R2: software drops low boot alias before dram
// R3: dram decode enabled by control bit 24
// R4: low boot alias turned off by bit 20
// R5: boot bytes packed to longs, contents repeat
// R6: primary boot region: jumper fitted selects flash
// R7: secondary boot region: selection inverted
// R8: dram/sram decoders here, other windows elsewhere
// R9: undecoded access ends by enabled bus timeout
// R10: reserved regions never acknowledge, timeout errors
// R11: narrow writes to local registers error
// R12: global registers take any width
// R13: software reads interrupt vector byte-wide
// R14: serial controllers take byte accesses only
// R15: network port command: upper word, lower word
// R16: nvram alias windows gate flash writes
// R17: slot pair i/o decodes and repeats
// R18: only transfer types 0..2 are mapped
// R19: timeout period parameter, one-cycle error
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module local_bus_decoder
	import lbd_pkg::*;
#(
	parameter int LB_TIMEOUT_CYC = LB_TIMEOUT_DEF
) (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	// local bus
	local_bus_if.decoder                lb,
	// board strap and external window controllers
	input  wire logic                   boot_select_jumper,
	input  wire logic                   ext_window_hit,
	// steering to memories and peripherals
	output target_t                     tgt_sel,
	output logic                        tgt_strobe,
	output logic [31:0]                 tgt_addr,
	output logic [1:0]                  tgt_size,
	output logic                        tgt_write,
	output logic [31:0]                 tgt_wdata,
	input  wire logic                   tgt_ack,
	input  wire logic [31:0]            tgt_rdata,
	// boot memory private bus
	output logic                        boot_cs_flash,
	output logic                        boot_cs_eprom,
	output logic [BOOT_DEV_AW-1:0]      boot_addr,
	output logic                        boot_rd,
	output logic                        boot_wr,
	output logic [7:0]                  boot_wdata,
	input  wire logic [7:0]             boot_rdata,
	// flash write permission
	output logic                        flash_write_enable
);
	typedef enum logic [1:0] {D_IDLE, D_BOOT, D_WAIT} dec_state_t;
	localparam logic [15:0] TO_LAST = 16'(LB_TIMEOUT_CYC - 1);

	dec_state_t  state;
	logic [31:0] boot_memory_control;
	logic [31:0] dram_control;
	logic [31:0] dram_base;
	logic [31:0] sram_base;
	logic [31:0] timer_control;
	logic [15:0] to_cnt;
	target_t     hit;
	logic [31:0] dram_lo;
	logic [31:0] sram_lo;
	logic [3:0]  lanes;
	logic        taken;
	logic        bad_width;
	logic        pk_start;
	logic        pk_done;
	logic [31:0] pk_rdata;
	logic [31:0] reg_rd;

	assign dram_lo = {dram_base[31:20], 20'h0};
	assign sram_lo = {sram_base[31:20], 20'h0};
	assign lanes   = byte_lanes(lb.size, lb.addr[1:0]);
	assign taken   = lb.req && (lb.tt <= TT_MAX) && (state == D_IDLE); // R18
	assign bad_width = (hit == TGT_LOCAL_CTRL_STATUS_REGS) && lb.write && (lb.size != SZ_LONG); // R11 R12
	assign pk_start  = taken && (hit == TGT_BOOT) && !bad_width;

	// address decode, fixed regions ahead of programmable windows, except the default sram range, which follows the dram window
	always_comb begin
		hit = TGT_NONE; // R9 R10
		if (in_range(lb.addr, BOOT_HI_LO, BOOT_HI_HI))
			hit = TGT_BOOT; // R1
		else if (!boot_memory_control[BOOT_LOW_OFF_BIT] && lb.addr <= BOOT_LOW_HI)
			hit = TGT_BOOT; // R1 R4
		else if (in_range(lb.addr, LOCAL_CTRL_STATUS_REGS_LO, LOCAL_CTRL_STATUS_REGS_HI))
			hit = TGT_LOCAL_CTRL_STATUS_REGS;
		else if (in_range(lb.addr, GLOBAL_CTRL_STATUS_REGS_LO, GLOBAL_CTRL_STATUS_REGS_HI))
			hit = TGT_GLOBAL_CTRL_STATUS_REGS;
		else if (in_range(lb.addr, MEMCTL_LO, MEMCTL_HI))
			hit = TGT_MEMCTL;
		else if (in_range(lb.addr, SCC_LO, SCC_HI))
			hit = TGT_SCC;
		else if (in_range(lb.addr, LAN_LO, LAN_HI))
			hit = TGT_LAN;
		else if (in_range(lb.addr, SCSI_LO, SCSI_HI))
			hit = TGT_SCSI;
		else if (in_range(lb.addr, IPIO_LO, IPIO_HI))
			hit = TGT_IP_IO;
		else if (in_range(lb.addr, PAIR_LO, PAIR_HI))
			hit = lb.addr[PAIR_CD_BIT] ? TGT_PAIR_CD : TGT_PAIR_AB; // R17
		else if (in_range(lb.addr, MODREG_LO, MODREG_HI))
			hit = TGT_MODREG;
		else if (in_range(lb.addr, NV_LO, NV_HI))
			hit = TGT_NVRAM; // R16
		else if (lb.addr >= VME16_LO)
			hit = TGT_EXT;
		else if (dram_control[DRAM_EN_BIT] && lb.addr >= dram_lo
			&& (lb.addr - dram_lo) < DRAM_WIN_BYTES)
			hit = TGT_DRAM; // R3 R8
		else if (in_range(lb.addr, SRAM_DEF_LO, SRAM_DEF_HI))
			hit = TGT_SRAM;
		else if (sram_base[SRAM_EN_BIT] && lb.addr >= sram_lo
			&& (lb.addr - sram_lo) < SRAM_WIN_BYTES)
			hit = TGT_SRAM; // R8
		else if (ext_window_hit)
			hit = TGT_EXT; // R8
	end

	// register read mux
	always_comb begin
		unique case (lb.addr[31:2])
			BOOT_CTRL_ADDR[31:2]:  reg_rd = boot_memory_control;
			DRAM_CTRL_ADDR[31:2]:  reg_rd = dram_control;
			DRAM_BASE_ADDR[31:2]:  reg_rd = dram_base;
			SRAM_BASE_ADDR[31:2]:  reg_rd = sram_base;
			TIMER_CTRL_ADDR[31:2]: reg_rd = timer_control;
			default:               reg_rd = 32'h0;
		endcase
	end

	// byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, nw, input logic [3:0] m);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (m[3-i])
				r[8*(3-i) +: 8] = nw[8*(3-i) +: 8];
		return r;
	endfunction : merge

	// decoder's own registers, written in the taking cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_memory_control <= REG_RST; // R1
			dram_control        <= REG_RST;
			dram_base           <= REG_RST;
			sram_base           <= REG_RST;
			timer_control       <= REG_RST;
		end else if (taken && hit == TGT_MEMCTL && lb.write) begin
			unique case (lb.addr[31:2])
				BOOT_CTRL_ADDR[31:2]:
					boot_memory_control <= merge(boot_memory_control, lb.wdata, lanes); // R4
				DRAM_CTRL_ADDR[31:2]:
					dram_control <= merge(dram_control, lb.wdata, lanes); // R3
				DRAM_BASE_ADDR[31:2]:
					dram_base <= merge(dram_base, lb.wdata, lanes);
				SRAM_BASE_ADDR[31:2]:
					sram_base <= merge(sram_base, lb.wdata, lanes);
				TIMER_CTRL_ADDR[31:2]:
					timer_control <= merge(timer_control, lb.wdata, lanes); // R9
				default: ;
			endcase
		end
	end

	// flash write permission follows the last nvram alias touched
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			flash_write_enable <= 1'b0;
		else if (taken && in_range(lb.addr, NV_DIS_LO, NV_EN_LO - 32'h1))
			flash_write_enable <= 1'b0; // R16
		else if (taken && in_range(lb.addr, NV_EN_LO, NV_HI))
			flash_write_enable <= 1'b1; // R16
	end

	// boot chip select: primary follows the jumper, secondary inverts it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_cs_flash <= 1'b0;
			boot_cs_eprom <= 1'b0;
		end else if (pk_start) begin
			boot_cs_flash <= boot_select_jumper ^ lb.addr[BOOT_SEC_BIT]; // R6 R7
			boot_cs_eprom <= !(boot_select_jumper ^ lb.addr[BOOT_SEC_BIT]); // R6 R7
		end else if (pk_done) begin
			boot_cs_flash <= 1'b0;
			boot_cs_eprom <= 1'b0;
		end
	end

	// transfer sequencing and termination
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state      <= D_IDLE;
			lb.ack     <= 1'b0;
			lb.transfer_error_ack     <= 1'b0;
			lb.rdata   <= 32'h0;
			tgt_sel    <= TGT_NONE;
			tgt_strobe <= 1'b0;
			tgt_addr   <= 32'h0;
			tgt_size   <= SZ_LONG;
			tgt_write  <= 1'b0;
			tgt_wdata  <= 32'h0;
			to_cnt     <= 16'h0;
		end else begin
			lb.ack     <= 1'b0;
			lb.transfer_error_ack     <= 1'b0;
			tgt_strobe <= 1'b0;
			unique case (state)
				D_IDLE: begin
					to_cnt <= 16'h0;
					if (taken) begin
						if (bad_width) begin
							lb.transfer_error_ack <= 1'b1; // R11
						end else if (hit == TGT_MEMCTL) begin
							lb.ack   <= 1'b1;
							lb.rdata <= reg_rd;
						end else if (hit == TGT_BOOT) begin
							state <= D_BOOT; // R5
						end else begin
							tgt_sel    <= hit;
							tgt_strobe <= (hit != TGT_NONE); // R10
							tgt_addr   <= lb.addr;
							tgt_size   <= lb.size;
							tgt_write  <= lb.write;
							tgt_wdata  <= lb.wdata;
							state      <= D_WAIT;
						end
					end
				end
				D_BOOT: begin
					if (pk_done) begin
						lb.ack   <= 1'b1;
						lb.rdata <= pk_rdata;
						state    <= D_IDLE;
					end
				end
				D_WAIT: begin
					to_cnt <= to_cnt + 16'h1;
					if (tgt_ack && tgt_sel != TGT_NONE) begin
						lb.ack   <= 1'b1;
						lb.rdata <= tgt_rdata;
						tgt_sel  <= TGT_NONE;
						state    <= D_IDLE;
					end else if (timer_control[TIMER_EN_BIT] && to_cnt >= TO_LAST) begin
						lb.transfer_error_ack  <= 1'b1; // R9 R10 R19
						tgt_sel <= TGT_NONE;
						state   <= D_IDLE;
					end
				end
				default: state <= D_IDLE;
			endcase
		end
	end

	// boot memory byte packer
	boot_byte_packer u_packer (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.start     (pk_start),
		.base_addr (lb.addr[BOOT_DEV_AW-1:0]),
		.lanes     (lanes),
		.write     (lb.write),
		.wdata     (lb.wdata),
		.wr_allow  (flash_write_enable),
		.done      (pk_done),
		.rdata     (pk_rdata),
		.dev_addr  (boot_addr),
		.dev_rd    (boot_rd),
		.dev_wr    (boot_wr),
		.dev_wdata (boot_wdata),
		.dev_rdata (boot_rdata)
	);
endmodule : local_bus_decoder

/* File: rtl/local_bus_master.sv */
// local bus master driven by software through a small register port
`timescale 1ns/10ps
module local_bus_master
	import lbd_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// software register port
	input  wire logic [2:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic [31:0]      sw_rdata,
	// local bus
	local_bus_if.master      lb
);
	typedef enum logic [1:0] {H_IDLE, H_WAIT} host_state_t;
	host_state_t state;
	logic [31:0] cmd_addr;
	logic [31:0] cmd_data;
	logic [5:0]  cmd_ctrl;
	logic [31:0] result;
	logic        second;
	logic        done;
	logic        err;
	logic        refused;
	logic        start;
	logic        scc_bad;
	logic [1:0]  nsize;

	assign nsize   = sw_wdata[HC_SIZE +: 2];
	assign start   = sw_wr && sw_addr == H_CTRL_IDX && state == H_IDLE;
	assign scc_bad = in_range(cmd_addr, SCC_LO, SCC_HI) && nsize != SZ_BYTE; // R14

	// replicate data onto the lanes of the access size
	function automatic logic [31:0] lanes_data(input logic [1:0] sz, input logic [31:0] d);
		unique case (sz)
			SZ_BYTE: return {4{d[7:0]}};
			SZ_WORD: return {2{d[15:0]}};
			default: return d;
		endcase
	endfunction : lanes_data

	// software-written command registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_addr <= 32'h0;
			cmd_data <= 32'h0;
			cmd_ctrl <= 6'h0;
		end else if (sw_wr && state == H_IDLE) begin
			if (sw_addr == H_ADDR_IDX)
				cmd_addr <= sw_wdata;
			if (sw_addr == H_DATA_IDX)
				cmd_data <= sw_wdata;
			if (sw_addr == H_CTRL_IDX)
				cmd_ctrl <= sw_wdata[5:0];
		end
	end

	// read data one cycle after the read strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			sw_rdata <= 32'h0;
		else if (sw_rd) begin
			unique case (sw_addr)
				H_ADDR_IDX: sw_rdata <= cmd_addr;
				H_DATA_IDX: sw_rdata <= cmd_data;
				H_CTRL_IDX: sw_rdata <= {26'h0, cmd_ctrl};
				H_STAT_IDX: sw_rdata <= {28'h0, refused, err, done, state != H_IDLE};
				H_RDAT_IDX: sw_rdata <= result;
				default:    sw_rdata <= 32'h0;
			endcase
		end else
			sw_rdata <= 32'h0;
	end

	// bus sequencing; a split write sends upper word then lower word
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state    <= H_IDLE;
			lb.req   <= 1'b0;
			lb.addr  <= 32'h0;
			lb.size  <= SZ_LONG;
			lb.write <= 1'b0;
			lb.tt    <= 2'h0;
			lb.wdata <= 32'h0;
			result   <= 32'h0;
			second   <= 1'b0;
			done     <= 1'b0;
			err      <= 1'b0;
			refused  <= 1'b0;
		end else begin
			lb.req <= 1'b0;
			unique case (state)
				H_IDLE: begin
					if (start) begin
						done    <= scc_bad;
						err     <= 1'b0;
						refused <= scc_bad; // R14
						second  <= 1'b0;
						if (!scc_bad) begin
							lb.req   <= 1'b1;
							lb.addr  <= cmd_addr;
							lb.write <= sw_wdata[HC_WRITE];
							lb.tt    <= sw_wdata[HC_TT +: 2];
							if (sw_wdata[HC_SPLIT] && sw_wdata[HC_WRITE]) begin
								lb.size  <= SZ_WORD;
								lb.wdata <= {2{cmd_data[31:16]}}; // R15
							end else begin
								lb.size  <= nsize;
								lb.wdata <= lanes_data(nsize, cmd_data);
							end
							state <= H_WAIT;
						end
					end
				end
				H_WAIT: begin
					if (lb.ack && cmd_ctrl[HC_SPLIT] && cmd_ctrl[HC_WRITE] && !second) begin
						second   <= 1'b1;
						lb.req   <= 1'b1;
						lb.addr  <= lb.addr + 32'h2;
						lb.wdata <= {2{cmd_data[15:0]}}; // R15
					end else if (lb.ack || lb.transfer_error_ack) begin
						result <= lb.rdata;
						err    <= lb.transfer_error_ack; // R9 R11
						done   <= 1'b1;
						state  <= H_IDLE;
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end
endmodule : local_bus_master

/* File: test/local_bus_assertions.sv */
// protocol checker for the local bus between master and decoder
`timescale 1ns/10ps
module local_bus_assertions
	import lbd_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// local bus
	input wire logic        req,
	input wire logic [31:0] addr,
	input wire logic [1:0]  size,
	input wire logic        write,
	input wire logic [1:0]  tt,
	input wire logic        ack,
	input wire logic        transfer_error_ack
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// requests that the decoder takes, by kind
	sequence take_s;
		req && tt <= TT_MAX;
	endsequence
	sequence boot_rd_s;
		take_s ##0 (!write && size == SZ_LONG && in_range(addr, BOOT_HI_LO, BOOT_HI_HI));
	endsequence
	sequence local_ctrl_status_regs_narrow_s;
		take_s ##0 (write && size != SZ_LONG && in_range(addr, LOCAL_CTRL_STATUS_REGS_LO, LOCAL_CTRL_STATUS_REGS_HI));
	endsequence
	// the two ends of a transfer
	ack_tea_excl_a: assert property (!(ack && transfer_error_ack)) else $error("ack with tea");
	ack_single_a: assert property (ack |=> !ack) else $error("ack too long");
	tea_single_a: assert property (transfer_error_ack |=> !transfer_error_ack) else $error("tea too long");
	boot_pack_a: assert property (boot_rd_s |=> !ack [*4] ##[1:2] ack)
		else $error("boot long read timing");
	local_ctrl_status_regs_narrow_a: assert property (local_ctrl_status_regs_narrow_s |=> transfer_error_ack) else $error("narrow write not refused");
	global_ctrl_status_regs_write_a: assert property (take_s ##0 (write && in_range(addr, GLOBAL_CTRL_STATUS_REGS_LO, GLOBAL_CTRL_STATUS_REGS_HI))
		|=> !transfer_error_ack [*4]) else $error("global write refused");
	memctl_ack_a: assert property (take_s ##0 in_range(addr, MEMCTL_LO, MEMCTL_HI)
		|=> ack && !transfer_error_ack) else $error("register access late");
	tt_ignore_a: assert property (req && tt == 2'h3 |=> (!ack && !transfer_error_ack) [*8])
		else $error("transfer type 3 answered");
	reserved_noack_a: assert property (take_s ##0 in_range(addr, 32'hfff00000, 32'hfff3ffff)
		|=> !ack [*8]) else $error("reserved area acknowledged");
endmodule : local_bus_assertions

/* File: test/local_bus_address_decode_tb.sv */
// self-checking bench: software drives the master, the bench plays the targets
`timescale 1ns/10ps
module local_bus_address_decode_tb
	import lbd_pkg::*;
;
	logic        sys_clk = 1'h0, nrst = 1'h0, sw_wr = 1'h0, sw_rd = 1'h0, tgt_ack = 1'h0;
	logic        jumper = 1'h0, ext_hit = 1'h0, tgt_strobe, cs_f, cs_e, fwe, t_wr, brd, bwr;
	logic [2:0]  sw_addr = 3'h0;
	logic [31:0] sw_wdata = 32'h0, tgt_rdata = 32'h0, sw_rdata, rd, st, dv, sd, t_addr, t_wd;
	logic [7:0]  boot_rdata;
	logic [19:0] boot_addr;
	logic [2:0]  cs_seen = 3'h0;
	logic        wr_seen = 1'h0;
	logic [1:0]  t_sz;
	logic [66:0] xl, xp;
	logic [44:0] tbl[19] = '{
		{32'hfff40000, 5'h03, 4'h6, TGT_NONE}, {32'hfff40002, 5'h05, 4'h6, TGT_NONE},
		{32'hfff45000, 5'h04, 4'ha, TGT_NONE}, {32'hfff45000, 5'h02, 4'h2, TGT_SCC},
		{32'hfff40000, 5'h01, 4'h2, TGT_LOCAL_CTRL_STATUS_REGS}, {32'hfff40003, 5'h02, 4'h2, TGT_LOCAL_CTRL_STATUS_REGS},
		{32'hfff40101, 5'h03, 4'h2, TGT_GLOBAL_CTRL_STATUS_REGS}, {32'hfff40102, 5'h05, 4'h2, TGT_GLOBAL_CTRL_STATUS_REGS},
		{32'hfff58400, 5'h00, 4'h2, TGT_PAIR_AB}, {32'hfff58600, 5'h00, 4'h2, TGT_PAIR_AB},
		{32'hfff58500, 5'h00, 4'h2, TGT_PAIR_CD}, {32'hfff00000, 5'h00, 4'h6, TGT_NONE},
		{32'hfff58800, 5'h00, 4'h6, TGT_NONE}, {32'hfffd0000, 5'h00, 4'h6, TGT_NONE},
		{32'hffc00000, 5'h00, 4'h6, TGT_NONE},
		{32'hffe00000, 5'h00, 4'h2, TGT_SRAM}, {32'hfff47000, 5'h00, 4'h2, TGT_SCSI},
		{32'hfff58000, 5'h00, 4'h2, TGT_IP_IO}, {32'hfffbc000, 5'h00, 4'h2, TGT_MODREG}};
	target_t     tgt_sel, sel_seen = TGT_NONE;
	int          err_count = 0, checks = 0;

	local_bus_if lbus ();
	local_bus_master local_bus_master_i (.sys_clk, .nrst, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
		.sw_rdata, .lb(lbus));
	local_bus_decoder #(.LB_TIMEOUT_CYC(8)) local_bus_decoder_i (.sys_clk, .nrst, .lb(lbus),
		.boot_select_jumper(jumper), .ext_window_hit(ext_hit), .tgt_sel, .tgt_strobe,
		.tgt_addr(t_addr), .tgt_size(t_sz), .tgt_write(t_wr), .tgt_wdata(t_wd), .tgt_ack,
		.tgt_rdata, .boot_cs_flash(cs_f), .boot_cs_eprom(cs_e), .boot_addr, .boot_rd(brd),
		.boot_wr(bwr),
		.boot_wdata(), .boot_rdata, .flash_write_enable(fwe));
	local_bus_assertions lb_chk (.sys_clk, .nrst, .req(lbus.req), .addr(lbus.addr),
		.size(lbus.size), .write(lbus.write), .tt(lbus.tt), .ack(lbus.ack), .transfer_error_ack(lbus.transfer_error_ack));

	always #25 sys_clk = ~sys_clk;
	// boot device: asynchronous bytes derived from the address
	assign boot_rdata = boot_addr[7:0] ^ 8'h3c;
	// far-side targets answer a strobe one cycle later; note what was steered
	always @(posedge sys_clk) begin
		tgt_ack   <= tgt_strobe;
		tgt_rdata <= tgt_strobe ? dv : ~dv;
		sel_seen  <= lbus.req ? TGT_NONE : (tgt_strobe ? tgt_sel : sel_seen);
		cs_seen   <= lbus.req ? 3'h0 : cs_seen | {cs_f, cs_e, brd};
		wr_seen   <= lbus.req ? 1'h0 : wr_seen | bwr;
		xl        <= tgt_strobe ? {t_sz, t_wr, t_addr, t_wd} : xl;
		xp        <= tgt_strobe ? xl : xp;
	end

	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one software port cycle, read data land in rd
	task automatic sw(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		sw_wr    <= w;
		sw_rd    <= !w;
		sw_addr  <= a;
		sw_wdata <= d;
		@(posedge sys_clk);
		sw_wr <= 1'h0;
		sw_rd <= 1'h0;
		#1 rd = sw_rdata;
	endtask : sw
	// whole transfer through the master, then compare the final status
	task automatic go(input logic [31:0] a, input logic [5:0] c, input logic [31:0] d,
		input logic [31:0] e);
		dv = $urandom;
		sw(1'h1, H_ADDR_IDX, a);
		sw(1'h1, H_DATA_IDX, d);
		sw(1'h1, H_CTRL_IDX, {26'h0, c});
		for (int i = 0; i < 40 && rd[1] !== 1'h1; i++) sw(1'h0, H_STAT_IDX, 32'h0);
		st = {28'h0, rd[3:0]};
		sw(1'h0, H_RDAT_IDX, 32'h0);
		chk("status", st, e);
	endtask : go
	// boot long expected: four bytes from consecutive offsets
	function automatic logic [31:0] boot_long(input logic [7:0] a);
		for (int i = 0; i < 4; i++) boot_long[31-8*i -: 8] = (a + i[7:0]) ^ 8'h3c;
	endfunction : boot_long
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	// watchdog far beyond the expected run
	initial begin
		#400us;
		err_count++;
		end_of_test;
	end
	initial begin
		dv = $urandom(32'ha226);
		repeat (6) @(posedge sys_clk);
		nrst <= 1'h1;
		go(BOOT_CTRL_ADDR, 6'h0, 32'h0, 32'h2);
		chk("boot ctrl", rd, REG_RST);
		go(DRAM_CTRL_ADDR, 6'h0, 32'h0, 32'h2);
		chk("dram ctrl", rd, REG_RST);
		for (int k = 0; k < 4; k++) begin
			jumper <= k[1];
			go(k[0] ? 32'hffa00010 : 32'hff900010, 6'h0, 32'h0, 32'h2);
			chk("boot cs", {29'h0, cs_seen}, (k[1] ^ k[0]) ? 32'h5 : 32'h3);
			chk("boot data", rd, boot_long(8'h10));
		end
		go(32'h00100014, 6'h0, 32'h0, 32'h2);
		chk("low boot", rd, boot_long(8'h14));
		go(TIMER_CTRL_ADDR, 6'h1, 32'h1, 32'h2);
		go(BOOT_CTRL_ADDR, 6'h1, 32'h00100000, 32'h2);
		go(32'h00100014, 6'h0, 32'h0, 32'h6);
		go(DRAM_CTRL_ADDR, 6'h1, 32'h01000000, 32'h2);
		go(32'h00000040, 6'h0, 32'h0, 32'h2);
		chk("dram data", rd, dv);
		chk("dram sel", {28'h0, sel_seen}, {28'h0, TGT_DRAM});
		foreach (tbl[j]) begin
			go(tbl[j][44:13], {1'h0, tbl[j][12:8]}, $urandom, {28'h0, tbl[j][7:4]});
			chk("steer", {28'h0, sel_seen}, {28'h0, tbl[j][3:0]});
			if (tbl[j][3:0] != TGT_NONE)
				chk("steer addr", xl[63:32], tbl[j][44:13]);
		end
		sd = $urandom;
		go(LAN_LO, 6'h25, sd, 32'h2);
		chk("split hi addr", xp[63:32], LAN_LO);
		chk("split hi data", xp[31:0], {2{sd[31:16]}});
		chk("split lo addr", xl[63:32], LAN_LO + 32'h2);
		chk("split lo data", xl[31:0], {2{sd[15:0]}});
		chk("split kind", {29'h0, xl[66:64]}, {29'h0, SZ_WORD, 1'h1});
		ext_hit <= 1'h1;
		go(32'hffc00000, 6'h0, 32'h0, 32'h2);
		chk("ext sel", {28'h0, sel_seen}, {28'h0, TGT_EXT});
		for (int k = 0; k < 2; k++) begin
			go(k ? NV_DIS_LO : NV_EN_LO, 6'h1, $urandom, 32'h2);
			chk("flash wr en", {31'h0, fwe}, k ? 32'h0 : 32'h1);
			go(32'hff900000, 6'h1, $urandom, 32'h2);
			chk("boot wr", {31'h0, wr_seen}, k ? 32'h0 : 32'h1);
		end
		go(BOOT_CTRL_ADDR, 6'h18, 32'h0, 32'h1);
		end_of_test;
	end
endmodule : local_bus_address_decode_tb
